// >>> vc_regs_pkg.sv
`default_nettype none

package vc_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses in configuration space)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h160;
    localparam logic [11:0] STAT_OFFSET = 12'h164;
    localparam logic [11:0] TABLE_OFFSET = 12'h170;
    localparam int TABLE_WORDS = 4;
    localparam int TABLE_PHASES = 32;
    localparam int PHASE_BITS = 4;

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int MAP_LSB = 0;
    localparam int LOAD_BIT = 16;
    localparam int SEL_LSB = 17;
    localparam int ID_LSB = 24;
    localparam int ENABLE_BIT = 31;

    // Status register field positions
    localparam int TBL_STATUS_BIT = 16;
    localparam int NEG_PENDING_BIT = 17;

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] MAP_RESET = 8'h00;
    localparam logic [7:0] MAP_WRITABLE = 8'hfe;
    localparam logic [2:0] ID_RESET_LOW = 3'h0;
    localparam logic [2:0] ID_RESET_HIGH = 3'h1;
    localparam logic [2:0] EXT_COUNT_ONE = 3'h1;
    localparam logic [31:0] PHASE_MASK = 32'h7777_7777;
    localparam logic [31:0] TABLE_RESET = 32'h0000_0000;

    // Port arbitration scheme codes
    typedef enum logic [2:0] {
        SCHEME_DEFAULT = 3'b000,
        SCHEME_WRR = 3'b011,
        SCHEME_TIME_WRR = 3'b100
    } arb_scheme_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
    } cfg_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } cfg_rsp_type;

    typedef struct packed {
        logic [7:0] class_to_channel_map;
        arb_scheme_type arb_select;
        logic [2:0] channel_identifier;
        logic channel_enable;
    } vc_ctrl_type;

endpackage

`default_nettype wire

// >>> arb_table_word.sv
`timescale 1ns/10ps
`default_nettype none

// One 32-bit word of the channel arbitration table, eight phases of four bits
module arb_table_word (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [3:0] be,
    input wire logic [31:0] wdata,
    output logic [31:0] q
);

    logic [31:0] word_r;
    logic [31:0] lane_mask;
    logic [31:0] word_nxt;

    // Byte lanes select which phases take the write; reserved nibble bit stays zero
    assign lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    assign word_nxt = ((word_r & ~lane_mask) | (wdata & lane_mask)) &
                      vc_regs_pkg::PHASE_MASK;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_r <= vc_regs_pkg::TABLE_RESET;
        end else if (wr_en) begin
            word_r <= word_nxt;
        end
    end

    assign q = word_r;

endmodule // arb_table_word

`default_nettype wire

// >>> vc_resource_regs.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Eight-bit map, one bit per traffic class, set means class uses this channel.
// - Map bit 0 is read-only zero; writes to it do nothing.
// - Map resets to zero; a preload port may override its default.
// - Writing one to load bit applies port table; reads return zero.
// - Scheme select keeps 000b, 011b, 100b; other codes store default 000b.
// - Three-bit read-write channel identifier field.
// - Identifier reads zero in reset, then takes one on the first edge after release when extended channel count is one, else zero.
// - Top control bit enables channel; resets disabled.
// - Table status sets whenever software writes a port table entry; resets zero.
// - Table status clears when hardware finishes the requested table load.
// - Negotiation pending reads one while negotiating, zero after; resets zero.
// - Each arbitration entry is four bits: three identifier bits, one reserved.
// - Arbitration table holds exactly 32 phase entries.
// - Eight phases per word, phase 0 lowest nibble, words at 00h to 0Ch.
module vc_resource_regs (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire vc_regs_pkg::cfg_req_type cfg_req,
    output vc_regs_pkg::cfg_rsp_type cfg_rsp,
    input wire logic [2:0] ext_channel_count,
    input wire logic preload_valid,
    input wire logic [7:0] preload_map,
    input wire logic port_table_written,
    input wire logic port_table_load_done,
    input wire logic negotiating,
    output logic port_table_load,
    output vc_regs_pkg::vc_ctrl_type vc_ctrl,
    output logic [127:0] channel_arbitration_table
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic wr;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_table;
    logic [1:0] table_idx;
    logic [11:0] table_rel;

    // Requests are single-cycle pulses, so nothing here ever stalls the bus
    assign wr = cfg_req.valid & cfg_req.write;
    // Full twelve-bit compares keep near aliases of the two registers unmapped
    assign hit_ctrl = cfg_req.addr == vc_regs_pkg::CTRL_OFFSET;
    assign hit_stat = cfg_req.addr == vc_regs_pkg::STAT_OFFSET;
    // Offset inside the table window; addresses below the base wrap high and miss
    assign table_rel = cfg_req.addr - vc_regs_pkg::TABLE_OFFSET;
    // Table spans four aligned words; anything else falls through to zero
    assign hit_table = (table_rel[11:4] == 8'h00) && (table_rel[1:0] == 2'b00);
    assign table_idx = table_rel[3:2];

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    vc_regs_pkg::vc_ctrl_type ctrl_r;
    vc_regs_pkg::vc_ctrl_type ctrl_nxt;
    logic id_loaded_r;
    logic ctrl_wr;
    logic [2:0] sel_wdata;
    vc_regs_pkg::arb_scheme_type sel_legal;
    logic [7:0] map_wdata;
    logic [2:0] id_strap;
    logic sel_is_wrr;
    logic sel_is_time_wrr;

    // Write data is split into fields here; byte lanes gate them further down
    assign ctrl_wr = wr & hit_ctrl;
    assign map_wdata = cfg_req.wdata[vc_regs_pkg::MAP_LSB +: 8] & vc_regs_pkg::MAP_WRITABLE;
    assign sel_wdata = cfg_req.wdata[vc_regs_pkg::SEL_LSB +: 3];
    // Unsupported scheme codes collapse to the default scheme rather than being kept,
    // so the arbiter never sees a code it cannot run
    assign sel_is_wrr = sel_wdata == vc_regs_pkg::SCHEME_WRR;
    assign sel_is_time_wrr = sel_wdata == vc_regs_pkg::SCHEME_TIME_WRR;
    assign sel_legal = sel_is_wrr ? vc_regs_pkg::SCHEME_WRR :
                       sel_is_time_wrr ? vc_regs_pkg::SCHEME_TIME_WRR :
                       vc_regs_pkg::SCHEME_DEFAULT;
    assign id_strap = (ext_channel_count == vc_regs_pkg::EXT_COUNT_ONE) ?
                      vc_regs_pkg::ID_RESET_HIGH : vc_regs_pkg::ID_RESET_LOW;

    // Next control value: byte lanes gate each field, reserved bits never stored
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (!id_loaded_r) begin
            ctrl_nxt.channel_identifier = id_strap;
        end
        // Preload comes first so that a software write to byte 0 in the same cycle wins
        if (preload_valid) begin
            ctrl_nxt.class_to_channel_map = preload_map & vc_regs_pkg::MAP_WRITABLE;
        end
        if (ctrl_wr && cfg_req.be[0]) begin
            ctrl_nxt.class_to_channel_map = map_wdata;
        end
        if (ctrl_wr && cfg_req.be[2]) begin
            ctrl_nxt.arb_select = sel_legal;
        end
        // Until the strap is caught, a write cannot replace the identifier
        if (ctrl_wr && cfg_req.be[3] && id_loaded_r) begin
            ctrl_nxt.channel_identifier = cfg_req.wdata[vc_regs_pkg::ID_LSB +: 3];
        end
        if (ctrl_wr && cfg_req.be[3]) begin
            ctrl_nxt.channel_enable = cfg_req.wdata[vc_regs_pkg::ENABLE_BIT];
        end
    end

    // Identifier strap is caught on the first edge after reset release, not in reset
    // Limitation: a channel count change after that edge waits for the next reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= '{vc_regs_pkg::MAP_RESET, vc_regs_pkg::SCHEME_DEFAULT,
                        vc_regs_pkg::ID_RESET_LOW, 1'b0};
            id_loaded_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            id_loaded_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Table load strobe and table status
    // ------------------------------------------------------------
    logic load_hit;
    logic load_r;
    logic load_pending_r;
    logic tbl_status_r;
    logic tbl_status_nxt;
    logic neg_r;

    // Only byte lane 2 carries the load bit; writes without it leave the loader alone
    assign load_hit = ctrl_wr & cfg_req.be[2] & cfg_req.wdata[vc_regs_pkg::LOAD_BIT];
    // A fresh entry write wins over a load completing in the same cycle
    assign tbl_status_nxt = port_table_written ? 1'b1 :
                            (load_pending_r && port_table_load_done) ? 1'b0 :
                            tbl_status_r;

    // Load bit is never stored: it only fires a one-cycle strobe to the loader
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_r <= 1'b0;
            load_pending_r <= 1'b0;
            tbl_status_r <= 1'b0;
            neg_r <= 1'b0;
        end else begin
            load_r <= load_hit;
            load_pending_r <= load_hit | (load_pending_r & ~port_table_load_done);
            tbl_status_r <= tbl_status_nxt;
            neg_r <= negotiating;
        end
    end

    // ------------------------------------------------------------
    // Channel arbitration table, one word module per four-byte row
    // ------------------------------------------------------------
    // Four rows of eight phases give the 32 entries; the row is address bits 3:2
    logic [31:0] table_q [vc_regs_pkg::TABLE_WORDS];

    // Each row decodes its own write strobe from the word index
    genvar gi;
    generate
        for (gi = 0; gi < vc_regs_pkg::TABLE_WORDS; gi = gi + 1) begin : g_row
            arb_table_word u_word (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .wr_en(wr && hit_table && (table_idx == 2'(gi))),
                .be(cfg_req.be),
                .wdata(cfg_req.wdata),
                .q(table_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] ctrl_rd;
    logic [31:0] stat_rd;
    logic [31:0] rd_mux;
    logic [127:0] table_flat;

    // Load bit and reserved fields read zero
    assign ctrl_rd = {ctrl_r.channel_enable, 4'h0, ctrl_r.channel_identifier, 4'h0,
                      ctrl_r.arb_select, 1'b0, 8'h00, ctrl_r.class_to_channel_map};
    assign stat_rd = {14'h0000, neg_r, tbl_status_r, 16'h0000};
    // Flat copy for the core: phase n sits at bits 4n+3 down to 4n
    assign table_flat = {table_q[3], table_q[2], table_q[1], table_q[0]};
    // The three hits never overlap, so the order of the selects is moot
    assign rd_mux = hit_ctrl ? ctrl_rd :
                    hit_stat ? stat_rd :
                    hit_table ? table_q[table_idx] :
                    32'h0000_0000;

    // Answer registered one cycle after the request; unmapped reads return zero
    // Writes are answered too, with zero data, so every request sees one ack
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp.ack <= cfg_req.valid;
            cfg_rsp.rdata <= (cfg_req.valid && !cfg_req.write) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Outputs toward the switch core
    // ------------------------------------------------------------
    // Mirrors trail the registers by one cycle; the lag buys a clean flop
    // boundary into the core, and software reads never see the difference
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vc_ctrl <= '0;
            channel_arbitration_table <= '0;
        end else begin
            vc_ctrl <= ctrl_r;
            channel_arbitration_table <= table_flat;
        end
    end

    // The load strobe leaves straight from its flop, one cycle after the write
    assign port_table_load = load_r;

endmodule // vc_resource_regs

`default_nettype wire

// >>> vc_resource_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Port checker for the channel register bank
// ------------------------------------------------------------
module vc_resource_regs_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire vc_regs_pkg::cfg_req_type cfg_req,
    input wire vc_regs_pkg::cfg_rsp_type cfg_rsp,
    input wire logic port_table_written,
    input wire logic port_table_load_done,
    input wire logic negotiating,
    input wire logic port_table_load,
    input wire vc_regs_pkg::vc_ctrl_type vc_ctrl,
    input wire logic [127:0] channel_arbitration_table
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Decoded requests; the request-driven checks key off what the bus really asked for
    wire logic rd_any = cfg_req.valid && !cfg_req.write;
    wire logic wr_any = cfg_req.valid && cfg_req.write;
    wire logic rd_ctrl = rd_any && cfg_req.addr == vc_regs_pkg::CTRL_OFFSET;
    wire logic rd_stat = rd_any && cfg_req.addr == vc_regs_pkg::STAT_OFFSET;
    wire logic wr_ctrl = wr_any && cfg_req.addr == vc_regs_pkg::CTRL_OFFSET;
    wire logic load_req = wr_ctrl && cfg_req.be[2] && cfg_req.wdata[vc_regs_pkg::LOAD_BIT];

    ack_timing_a: assert property (cfg_rsp.ack == $past(cfg_req.valid))
        else $error("ack mistimed");
    map_lsb_zero_a: assert property (!vc_ctrl.class_to_channel_map[0])
        else $error("map bit0 set");
    load_pulse_a: assert property (port_table_load == $past(load_req))
        else $error("load pulse wrong");
    ctrl_read_zero_a: assert property (rd_ctrl |=>
        cfg_rsp.rdata[30:27] == 4'h0 && cfg_rsp.rdata[23:20] == 4'h0 &&
        cfg_rsp.rdata[16:8] == 9'h0)
        else $error("ctrl zero bits set");
    select_legal_a: assert property (vc_ctrl.arb_select inside {3'h0, 3'h3, 3'h4})
        else $error("illegal scheme");
    enable_follow_a: assert property (wr_ctrl && cfg_req.be[3] |=>
        ##1 vc_ctrl.channel_enable == $past(cfg_req.wdata[31], 2))
        else $error("enable not stored");
    // A finished load in the cycle after the entry write may clear the flag legally
    table_status_a: assert property (
        port_table_written ##1 !port_table_load_done ##1 rd_stat |=> cfg_rsp.rdata[16])
        else $error("table status missing");
    neg_pending_a: assert property (negotiating [*3] ##0 rd_stat |=> cfg_rsp.rdata[17])
        else $error("pending missing");
    stat_zero_a: assert property (rd_stat |=>
        cfg_rsp.rdata[31:18] == 14'h0 && cfg_rsp.rdata[15:0] == 16'h0)
        else $error("stat zero bits set");
    nibble_rsvd_a: assert property (
        (channel_arbitration_table & ~{4{vc_regs_pkg::PHASE_MASK}}) == 128'h0)
        else $error("reserved phase bit set");

    load_seen_c: cover property (port_table_load);
    status_seen_c: cover property (rd_stat ##1 cfg_rsp.rdata[16]);
    table_seen_c: cover property (channel_arbitration_table != 128'h0);
endmodule // vc_resource_regs_chk

bind vc_resource_regs vc_resource_regs_chk chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .port_table_written(port_table_written),
    .port_table_load_done(port_table_load_done),
    .negotiating(negotiating), .port_table_load(port_table_load), .vc_ctrl(vc_ctrl),
    .channel_arbitration_table(channel_arbitration_table));

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Register bank bench
// ------------------------------------------------------------
module tb_top;
    localparam logic [11:0] CTRL = vc_regs_pkg::CTRL_OFFSET;
    localparam logic [11:0] STAT = vc_regs_pkg::STAT_OFFSET;
    localparam logic [11:0] TBL = vc_regs_pkg::TABLE_OFFSET;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    vc_regs_pkg::cfg_req_type cfg_req = '0;
    vc_regs_pkg::cfg_rsp_type cfg_rsp;
    vc_regs_pkg::vc_ctrl_type vc_ctrl;
    logic [2:0] ext_count = 3'h1;
    logic pre_v = 1'b0;
    logic [7:0] pre_map = 8'h00;
    logic tbl_wr = 1'b0;
    logic ld_done = 1'b0;
    logic neg = 1'b0;
    logic ld_pulse;
    logic [127:0] arb_tbl;
    logic [31:0] rd;
    logic ld;
    logic [31:0] exp_val;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #20 sys_clk = ~sys_clk;

    vc_resource_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_rsp(cfg_rsp), .ext_channel_count(ext_count), .preload_valid(pre_v),
        .preload_map(pre_map), .port_table_written(tbl_wr), .port_table_load_done(ld_done),
        .negotiating(neg), .port_table_load(ld_pulse), .vc_ctrl(vc_ctrl),
        .channel_arbitration_table(arb_tbl));

    task automatic report_and_stop();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One request pulse; the answer stands one cycle and is taken at the next edge
    task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge sys_clk);
        cfg_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d, be: be};
        @(posedge sys_clk);
        cfg_req.valid <= 1'b0;
        @(posedge sys_clk);
        check("ack", 32'h1, {31'h0, cfg_rsp.ack});
        rd = cfg_rsp.rdata;
        ld = ld_pulse;
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0, 4'h0);
        check(what, exp, rd);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk("ctrl reset", CTRL, 32'h0100_0000);
        rd_chk("stat reset", STAT, 32'h0);
        $display("reset test done");
        access(1'b1, CTRL, 32'hffff_ffff, 4'hf);
        check("load", 32'h1, {31'h0, ld});
        rd_chk("ctrl all ones", CTRL, 32'h8700_00fe);
        check("vc_ctrl", {17'h0, 8'hfe, 3'h0, 3'h7, 1'b1}, 32'(vc_ctrl));
        // Every scheme code; illegal ones must fall back to the default
        for (int c = 0; c < 8; c++) begin
            access(1'b1, CTRL, 32'(c) << 17, 4'h4);
            exp_val = (c == 0 || c == 3 || c == 4) ? 32'(c) << 17 : 32'h0;
            rd_chk("select", CTRL, 32'h8700_00fe | exp_val);
        end
        access(1'b1, CTRL, 32'h0000_0055, 4'h1);
        rd_chk("map", CTRL, 32'h8700_0054);
        @(posedge sys_clk);
        pre_map <= 8'h0f;
        pre_v <= 1'b1;
        @(posedge sys_clk);
        pre_v <= 1'b0;
        rd_chk("preload", CTRL, 32'h8700_000e);
        $display("control test done");
        for (int w = 0; w < 4; w++) begin
            access(1'b1, TBL + 12'(4 * w), 32'hfedc_ba98 + 32'(w), 4'hf);
        end
        for (int w = 0; w < 4; w++) begin
            exp_val = (32'hfedc_ba98 + 32'(w)) & 32'h7777_7777;
            rd_chk("table", TBL + 12'(4 * w), exp_val);
            check("table out", exp_val, arb_tbl[32 * w +: 32]);
        end
        rd_chk("unmapped", 12'h180, 32'h0);
        $display("table test done");
        access(1'b1, STAT, 32'hffff_ffff, 4'hf);
        // Retire the load that the all-ones control write asked for
        @(posedge sys_clk);
        ld_done <= 1'b1;
        @(posedge sys_clk);
        ld_done <= 1'b0;
        rd_chk("stat ro", STAT, 32'h0);
        @(posedge sys_clk);
        tbl_wr <= 1'b1;
        @(posedge sys_clk);
        tbl_wr <= 1'b0;
        rd_chk("stat set", STAT, 32'h0001_0000);
        // A finished load with none requested must not clear the flag
        @(posedge sys_clk);
        ld_done <= 1'b1;
        @(posedge sys_clk);
        ld_done <= 1'b0;
        rd_chk("stat kept", STAT, 32'h0001_0000);
        access(1'b1, CTRL, 32'h0001_0000, 4'h4);
        check("load", 32'h1, {31'h0, ld});
        @(posedge sys_clk);
        ld_done <= 1'b1;
        @(posedge sys_clk);
        ld_done <= 1'b0;
        rd_chk("stat clear", STAT, 32'h0);
        neg <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk("pending", STAT, 32'h0002_0000);
        neg <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd_chk("pending off", STAT, 32'h0);
        $display("status test done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        ext_count <= 3'h0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk("ctrl strap zero", CTRL, 32'h0);
        $display("second reset test done");
        report_and_stop();
    end
endmodule // tb_top

`default_nettype wire
